// ===== logic/wdt_regs.vh
// Purpose: Register offsets, field positions and timing counts
// Assumes: Wishbone byte addresses, 8-bit registers in the low lanes
// Notes: Definitions only
`ifndef WDT_REGS_VH
`define WDT_REGS_VH
`define ADR_CTRL 8'h60
`define ADR_CAUSE 8'h64
`define ADR_IRQ_STAT 8'h68
`define ADR_IRQ_MASK 8'h6C
`define CTRL_IF 7
`define CTRL_IE 6
`define CTRL_P3 5
`define CTRL_CE 4
`define CTRL_RE 3
`define CAUSE_WATCHDOG_RESET_FLAG 3
`define CAUSE_EXT 1
`define CAUSE_POR 0
`define IRQ_TIMEOUT 0
`define IRQ_WDRESET 1
`define CE_HOLD_CYCLES 3'h4
`define PRESC_MAX 4'h9
`define BASE_SHIFT 11
`define OSC_HZ 128000
`define CLK_HZ 100000000
`endif

// ===== logic/watchdog_timer_reset_flags.v
// Purpose: Watchdog timer with timed change protection and reset-cause flags
// Assumes: Single 100 MHz clock; oscillator tick is a one-cycle enable pulse
// Notes: Registers reached over classic Wishbone
`timescale 1ns/100ps
`default_nettype none
`include "wdt_regs.vh"
// How it works
// - Pin reset sets pin flag; power-on or software zero write clears it.
// - Power-on sets power flag; only a software zero write clears it.
// - Time-out in interrupt operation sets the watchdog interrupt flag.
// - Vector taken or writing one clears the flag; zero does nothing.
// - Interrupt requested only when flag, enable and global enable are set.
// - Vector taken in combined mode clears enable and flag.
// - Combined mode: unserviced flag at next time-out gives system reset.
// - Fuse off: enables 00 stop, 01 interrupt, 10 reset, 11 both.
// - Fuse programmed (0) forces reset mode regardless of enable bits.
// - Clearing reset-enable or prescale change only while change-enable set.
// - Change-enable clears itself four clock cycles after being written one.
// - Reset-enable reads set and stays set while watchdog reset flag set.
// - Code 0000 gives 2048 oscillator cycles, doubling to 1048576 at 1001.
// - Watchdog reset sets its flag; power-on or software zero clears it.
// - Counter advances on the 128 kHz oscillator tick only.
// - Restart instruction clears the counter.
module watchdog_timer_reset_flags (
  input wire clk_i,
  input wire rst_i,
  input wire por_i,
  input wire pin_reset_i,
  input wire osc_tick_i,
  input wire wdr_i,
  input wire vector_taken_i,
  input wire global_ie_i,
  input wire wd_always_on_fuse_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output wire wd_irq_req_o,
  output reg sys_reset_o,
  output wire irq_o
);
  reg wd_interrupt_flag_r;
  reg wd_interrupt_enable_r;
  reg reset_enable_r;
  reg change_enable_r;
  reg [3:0] wd_prescale_code_r;
  reg [2:0] ce_cnt_r;
  reg power_on_flag_r;
  reg pin_reset_flag_r;
  reg watchdog_reset_flag_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg [20:0] count_r;
  // Bus decode
  wire [20:0] limit;
  wire wr;
  wire rd;
  wire wr_ctrl;
  wire wr_cause;
  wire wr_stat;
  wire wr_mask;
  // Event terms
  wire vec_combined;
  wire [1:0] stat_set;
  wire [1:0] stat_clr;
  wire timeout;
  wire fuse_prog;
  wire re_eff;
  wire ie_eff;
  wire int_mode;
  wire fire_reset;
  wire [3:0] new_code;
  wire [7:0] ctrl_rd;
  wire [7:0] cause_rd;
  reg [31:0] rd_nxt;

  // Time-out length in oscillator cycles
  function [20:0] timeout_len;
    input [3:0] code;
    reg [3:0] c;
    begin
      c = (code > `PRESC_MAX) ? `PRESC_MAX : code;
      timeout_len = 21'h000001 << (c + `BASE_SHIFT);
    end
  endfunction

  // Register address match
  function adr_hit;
    input [7:0] adr;
    input [7:0] reg_adr;
    begin
      adr_hit = (adr == reg_adr);
    end
  endfunction

  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign rd = cyc_i && stb_i && !ack_o;
  assign wr_ctrl = wr && adr_hit(adr_i, `ADR_CTRL);
  assign wr_cause = wr && adr_hit(adr_i, `ADR_CAUSE);
  assign wr_stat = wr && adr_hit(adr_i, `ADR_IRQ_STAT);
  assign wr_mask = wr && adr_hit(adr_i, `ADR_IRQ_MASK);
  assign fuse_prog = !wd_always_on_fuse_i;
  assign re_eff = fuse_prog || reset_enable_r || watchdog_reset_flag_r;
  assign ie_eff = !fuse_prog && wd_interrupt_enable_r;
  assign int_mode = ie_eff;
  assign limit = timeout_len(wd_prescale_code_r);
  assign timeout = osc_tick_i && (count_r == limit - 21'h000001);
  // Reset when reset-only, or combined with flag still pending
  assign fire_reset = timeout && re_eff && (!ie_eff || wd_interrupt_flag_r);
  assign wd_irq_req_o = wd_interrupt_flag_r && wd_interrupt_enable_r && global_ie_i;
  assign irq_o = |(irq_stat_r & irq_mask_r);
  assign new_code = {dat_i[`CTRL_P3], dat_i[2:0]};
  assign ctrl_rd = {wd_interrupt_flag_r, ie_eff, wd_prescale_code_r[3], change_enable_r,
                    re_eff, wd_prescale_code_r[2:0]};
  assign cause_rd = {4'h0, watchdog_reset_flag_r, 1'b0, pin_reset_flag_r, power_on_flag_r};
  // Vector taken while in combined mode
  assign vec_combined = vector_taken_i && re_eff && ie_eff;
  // Status events and write-one clears
  assign stat_set = {sys_reset_o, timeout && int_mode};
  assign stat_clr = wr_stat ? dat_i[1:0] : 2'h0;

  // Counter on oscillator ticks
  always @(posedge clk_i) begin
    if (rst_i || wdr_i || !(re_eff || ie_eff)) begin
      count_r <= 21'h000000;
    end else if (timeout) begin
      count_r <= 21'h000000;
    end else if (osc_tick_i) begin
      count_r <= count_r + 21'h000001;
    end
  end

  // Reset request pulse, one cycle after the time-out tick
  always @(posedge clk_i) begin
    if (rst_i) begin
      sys_reset_o <= 1'b0;
    end else begin
      sys_reset_o <= fire_reset;
    end
  end

  // Change-enable window and its cycle count
  always @(posedge clk_i) begin
    if (rst_i) begin
      change_enable_r <= 1'b0;
      ce_cnt_r <= 3'h0;
    end else if (wr_ctrl && dat_i[`CTRL_CE]) begin
      change_enable_r <= 1'b1;
      ce_cnt_r <= 3'h0;
    end else if (change_enable_r) begin
      if (ce_cnt_r == `CE_HOLD_CYCLES - 3'h1) begin
        change_enable_r <= 1'b0;
      end
      ce_cnt_r <= ce_cnt_r + 3'h1;
    end
  end

  // Interrupt enable, dropped by the vector in combined mode
  always @(posedge clk_i) begin
    if (rst_i) begin
      wd_interrupt_enable_r <= 1'b0;
    end else if (vec_combined) begin
      wd_interrupt_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      wd_interrupt_enable_r <= dat_i[`CTRL_IE];
    end
  end

  // Reset enable, set freely, cleared only inside the window
  always @(posedge clk_i) begin
    if (rst_i) begin
      reset_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      if (dat_i[`CTRL_RE]) begin
        reset_enable_r <= 1'b1;
      end else if (change_enable_r && !watchdog_reset_flag_r) begin
        reset_enable_r <= 1'b0;
      end
    end
  end

  // Prescale code, changed only inside the window
  always @(posedge clk_i) begin
    if (rst_i) begin
      wd_prescale_code_r <= 4'h0;
    end else if (wr_ctrl && change_enable_r) begin
      wd_prescale_code_r <= new_code;
    end
  end

  // Interrupt flag, set beats clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      wd_interrupt_flag_r <= 1'b0;
    end else if (timeout && int_mode) begin
      wd_interrupt_flag_r <= 1'b1;
    end else if (vector_taken_i || (wr_ctrl && dat_i[`CTRL_IF])) begin
      wd_interrupt_flag_r <= 1'b0;
    end
  end

  // Power-on flag, kept through system reset
  always @(posedge clk_i) begin
    if (por_i) begin
      power_on_flag_r <= 1'b1;
    end else if (wr_cause && !dat_i[`CAUSE_POR]) begin
      power_on_flag_r <= 1'b0;
    end
  end

  // Pin reset flag
  always @(posedge clk_i) begin
    if (por_i) begin
      pin_reset_flag_r <= 1'b0;
    end else if (pin_reset_i) begin
      pin_reset_flag_r <= 1'b1;
    end else if (wr_cause && !dat_i[`CAUSE_EXT]) begin
      pin_reset_flag_r <= 1'b0;
    end
  end

  // Watchdog reset flag
  always @(posedge clk_i) begin
    if (por_i) begin
      watchdog_reset_flag_r <= 1'b0;
    end else if (sys_reset_o) begin
      watchdog_reset_flag_r <= 1'b1;
    end else if (wr_cause && !dat_i[`CAUSE_WATCHDOG_RESET_FLAG]) begin
      watchdog_reset_flag_r <= 1'b0;
    end
  end

  // Sticky status, set beats write-one clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= 2'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~stat_clr) | stat_set;
    end
  end

  // Interrupt mask
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= 2'h0;
    end else if (wr_mask) begin
      irq_mask_r <= dat_i[1:0];
    end
  end

  // Read mux
  always @* begin
    case (adr_i)
      `ADR_CTRL: rd_nxt = {24'h000000, ctrl_rd};
      `ADR_CAUSE: rd_nxt = {24'h000000, cause_rd};
      `ADR_IRQ_STAT: rd_nxt = {30'h00000000, irq_stat_r};
      `ADR_IRQ_MASK: rd_nxt = {30'h00000000, irq_mask_r};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // Single-cycle acknowledge
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= rd;
    end
  end

  // Read data register
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (rd) begin
      dat_o <= rd_nxt;
    end
  end
endmodule // watchdog_timer_reset_flags
`default_nettype wire

// ===== tb/wdt_chk_properties.sv
// Purpose: Port checks for the watchdog block
// Assumes: One clock, rst_i sync high
// Notes: Bound after the module
`timescale 1ns/100ps
`default_nettype none
module wdt_chk (
  input wire clk_i,
  input wire rst_i,
  input wire osc_tick_i,
  input wire wdr_i,
  input wire global_ie_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire wd_irq_req_o,
  input wire sys_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = cyc_i & stb_i & ~ack_o;
  ack_due_a: assert property (req |=> ack_o) else $error("ack late");
  ack_one_a: assert property (ack_o |=> !ack_o) else $error("ack held");
  hi_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper set");
  hole_zero_a: assert property (req && !we_i && adr_i == 8'h70 |=> dat_o == 32'h0)
    else $error("hole nonzero");
  irq_gate_a: assert property (wd_irq_req_o |-> global_ie_i) else $error("irq ungated");
  rst_one_a: assert property (sys_reset_o |=> !sys_reset_o) else $error("reset held");
  rst_tick_a: assert property (sys_reset_o |-> $past(osc_tick_i)) else $error("no tick");
  wdr_quiet_a: assert property (wdr_i |-> ##2 !sys_reset_o) else $error("reset early");
  cover property (sys_reset_o);
  cover property (wd_irq_req_o);
  cover property (req && we_i);
endmodule // wdt_chk
bind watchdog_timer_reset_flags wdt_chk wdt_chk_inst (.clk_i, .rst_i, .osc_tick_i, .wdr_i,
  .global_ie_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .wd_irq_req_o, .sys_reset_o);
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the watchdog block
// Assumes: Tick every cycle while timing
// Notes: Cause flags modelled in an int
`timescale 1ns/100ps
`default_nettype none
`include "wdt_regs.vh"
module tb_top;
  logic clk_i = 0, rst_i = 1, por_i = 1, pin_reset_i = 0, osc_tick_i = 0, wdr_i = 0;
  logic vector_taken_i = 0, global_ie_i = 1, fuse = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 0;
  logic [31:0] dat_i = 0, rd;
  wire [31:0] dat_o;
  wire ack_o, wd_irq_req_o, sys_reset_o, irq_o;
  int fails = 0, checked = 0, n, cause_m;
  always #5 clk_i = ~clk_i;
  watchdog_timer_reset_flags watchdog_timer_reset_flags_inst (.clk_i, .rst_i, .por_i,
    .pin_reset_i, .osc_tick_i, .wdr_i, .vector_taken_i, .global_ie_i, .wd_always_on_fuse_i(fuse),
    .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .wd_irq_req_o,
    .sys_reset_o, .irq_o);
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) fails++;
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, m, input logic [31:0] e);
    bus(0, a, 0);
    cmp("read", e, rd & m);
  endtask
  task automatic pls(input int k);
    @(posedge clk_i);
    {pin_reset_i, wdr_i, vector_taken_i} <= 3'h1 << k;
    @(posedge clk_i);
    {pin_reset_i, wdr_i, vector_taken_i} <= 3'h0;
  endtask
  task automatic wt(input bit r);
    n = 0;
    while ((r ? sys_reset_o : wd_irq_req_o) !== 1'b1 && n < 4300) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    results;
  end
  initial begin
    n = $urandom(46);
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    por_i <= 0;
    cause_m = 1;
    rdc(`ADR_CAUSE, 8'h0B, cause_m);
    bus(1, `ADR_CAUSE, 0);
    cause_m = 0;
    rdc(`ADR_CAUSE, 8'h0B, cause_m);
    pls(2);
    cause_m = 2;
    rdc(`ADR_CAUSE, 8'h0B, cause_m);
    bus(1, 8'h70, $urandom);
    rdc(8'h70, 8'hFF, 0);
    bus(1, `ADR_CTRL, 8'h21);
    rdc(`ADR_CTRL, 8'h27, 0);
    bus(1, `ADR_CTRL, 8'h18);
    rdc(`ADR_CTRL, 8'h10, 8'h10);
    rdc(`ADR_CTRL, 8'h10, 0);
    bus(1, `ADR_CTRL, 8'h18);
    bus(1, `ADR_CTRL, 8'h41);
    rdc(`ADR_CTRL, 8'hFF, 8'h41);
    bus(1, `ADR_IRQ_MASK, 1);
    osc_tick_i <= 1;
    pls(1);
    wt(0);
    cmp("period", 1, n > 4000 && n < 4200);
    osc_tick_i <= 0;
    bus(1, `ADR_CTRL, 8'h41);
    rdc(`ADR_CTRL, 8'hC0, 8'hC0);
    cmp("irq", 1, irq_o);
    global_ie_i <= 0;
    @(posedge clk_i);
    cmp("req", 0, wd_irq_req_o);
    global_ie_i <= 1;
    bus(1, `ADR_IRQ_STAT, 1);
    cmp("irq", 0, irq_o);
    pls(0);
    rdc(`ADR_CTRL, 8'hC0, 8'h40);
    bus(1, `ADR_CTRL, 8'h49);
    osc_tick_i <= 1;
    pls(1);
    wt(0);
    wt(1);
    cmp("reset", 1, n > 4000 && n < 4200);
    osc_tick_i <= 0;
    cause_m = cause_m | 8;
    rdc(`ADR_CAUSE, 8'h0B, cause_m);
    pls(0);
    rdc(`ADR_CTRL, 8'hC8, 8'h08);
    bus(1, `ADR_CTRL, 8'h18);
    bus(1, `ADR_CTRL, 8'h01);
    rdc(`ADR_CTRL, 8'h08, 8'h08);
    bus(1, `ADR_CAUSE, 8'h07);
    rdc(`ADR_CTRL, 8'h08, 8'h08);
    cause_m = 2;
    rdc(`ADR_CAUSE, 8'h0B, cause_m);
    bus(1, `ADR_CTRL, 8'h18);
    bus(1, `ADR_CTRL, 8'h40);
    rdc(`ADR_CTRL, 8'h48, 8'h40);
    fuse <= 0;
    rdc(`ADR_CTRL, 8'h48, 8'h08);
    results;
  end
endmodule // tb_top
`default_nettype wire
